/* verilog/cdrw_recovery.sv */
// Clock and data recovery with frame timing for the selective wake decoder.
// ----------------------------------------------------------------
// Overview of operation
// - With recovery enabled, edges retune the bit time; disabled, no retune happens.
// - Two-bit clock select scales the bit time quanta count.
// - Reaching either limit discards measurements and reloads programmed quanta.
// - Sample point setting defaults to about 80 percent of the bit.
// - Bus silence timeout expires between 0.6 and 1.2 seconds of inactivity.
// - Wake reaction follows a valid pattern or frame within 100 microseconds.
// - Wake drives the interrupt low in stop, raises main supply in sleep.
// - Bit times down to one microsecond are decoded.
// - In tolerant mode a new frame start needs 6 to 10 recessive bits.
// - Tolerant filter ignores dominant pulses under 5 or 2.5 percent of bit; the code ignores only pulses up to 1/32 or 1/64 of bit.
// - After the format bit, longer pulses count as dominant data bits.
// - Tolerance applies for slow arbitration until the format bit is seen.
// - Tolerance filter thresholds apply only with the normal receiver selected.
// - Lower filter class for four times rate, higher for ten times.
// - Extended data length set stops decoding until the frame end.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module cdrw_recovery import cdrw_pkg::*; #(
    parameter int SILENCE_CYCLES = SILENCE_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Bus receive pin and protocol events
    input wire logic can_rx_i,
    input wire logic edl_bit_i,
    input wire logic wake_pattern_i,
    input wire logic wake_frame_i,
    // Power mode
    input wire logic stop_mode_i,
    input wire logic sleep_mode_i,
    // Decoder outputs
    output logic sample_strobe_o,
    output logic sampled_bit_o,
    output logic frame_active_o,
    output logic bus_silent_o,
    // Wake outputs
    output logic interrupt_output_low_o,
    output logic main_supply_output_o
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [3:0] ctrl_reg, ctrl_next;
    logic [1:0] clk_sel_reg, clk_sel_next;
    logic [7:0] btq_reg, btq_next;
    logic [5:0] spp_reg, spp_next;
    logic [7:0] upper_reg, upper_next, lower_reg, lower_next;
    logic wake_reg, wake_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic [15:0] bt_reg;
    logic silent_reg, skip_w, wake_evt;
    cdrw_state_t state_reg;
    logic wr;
    logic [31:0] rd;
    always_comb begin
        wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0];
        ctrl_next = ctrl_reg;
        clk_sel_next = clk_sel_reg;
        btq_next = btq_reg;
        spp_next = spp_reg;
        upper_next = upper_reg;
        lower_next = lower_reg;
        wake_next = wake_reg;
        if (wr) begin
            if (wb_adr_i == ADR_CTRL) begin
                ctrl_next = wb_dat_i[3:0];
            end else if (wb_adr_i == ADR_CLK) begin
                clk_sel_next = wb_dat_i[1:0];
            end else if (wb_adr_i == ADR_BTQ) begin
                btq_next = wb_dat_i[7:0];
            end else if (wb_adr_i == ADR_SPP) begin
                spp_next = wb_dat_i[5:0];
            end else if (wb_adr_i == ADR_UPPER) begin
                upper_next = wb_dat_i[7:0];
            end else if (wb_adr_i == ADR_LOWER) begin
                lower_next = wb_dat_i[7:0];
            end else if (wb_adr_i == ADR_WAKE && wb_dat_i[BIT_WAKE_FLAG]) begin
                wake_next = 1'b0;
            end
        end
        // A wake event wins over a clear in the same cycle.
        if (wake_evt) begin
            wake_next = 1'b1;
        end
        rd = 32'h0;
        if (wb_adr_i == ADR_CTRL) begin
            rd[3:0] = ctrl_reg;
        end else if (wb_adr_i == ADR_CLK) begin
            rd[1:0] = clk_sel_reg;
        end else if (wb_adr_i == ADR_BTQ) begin
            rd[7:0] = btq_reg;
        end else if (wb_adr_i == ADR_SPP) begin
            rd[5:0] = spp_reg;
        end else if (wb_adr_i == ADR_UPPER) begin
            rd[7:0] = upper_reg;
        end else if (wb_adr_i == ADR_LOWER) begin
            rd[7:0] = lower_reg;
        end else if (wb_adr_i == ADR_STATUS) begin
            rd[15:0] = bt_reg;
            rd[BIT_ST_SILENT] = silent_reg;
            rd[BIT_ST_FRAME] = (state_reg == CDRW_FRAME);
            rd[BIT_ST_SKIP] = skip_w;
            rd[BIT_ST_WAKE] = wake_reg;
        end else if (wb_adr_i == ADR_WAKE) begin
            rd[BIT_WAKE_FLAG] = wake_reg;
        end
        ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
        dat_next = ack_next ? rd : 32'h0;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RST;
            clk_sel_reg <= CLK_RST;
            btq_reg <= BTQ_RST;
            spp_reg <= SPP_RST;
            upper_reg <= UPPER_RST;
            lower_reg <= LOWER_RST;
            wake_reg <= 1'b0;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            clk_sel_reg <= clk_sel_next;
            btq_reg <= btq_next;
            spp_reg <= spp_next;
            upper_reg <= upper_next;
            lower_reg <= lower_next;
            wake_reg <= wake_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    // ------------------------------------------------------------
    // Input synchroniser and glitch filter
    // ------------------------------------------------------------
    logic rx_m_reg, rx_s_reg, rx_f_reg, rx_f_next;
    logic [15:0] dom_reg, dom_next, glitch_thr, dom_thr;
    logic tol_filt;
    always_comb begin
        // Thresholds stay under 5 or 2.5 percent, and under 17.5 or 8.75 percent.
        tol_filt = ctrl_reg[BIT_FD_EN] & ~ctrl_reg[BIT_RX_SEL];
        glitch_thr = 16'h0;
        dom_thr = 16'h0;
        if (tol_filt) begin
            glitch_thr = ctrl_reg[BIT_FILT_CLASS] ? (bt_reg >> 6) : (bt_reg >> 5);
            dom_thr = ctrl_reg[BIT_FILT_CLASS] ? (bt_reg >> 4) : (bt_reg >> 3);
        end
        dom_next = rx_s_reg ? 16'h0 : ((dom_reg == 16'hFFFF) ? dom_reg : dom_reg + 16'h1);
        rx_f_next = rx_s_reg ? 1'b1 : ((dom_reg >= glitch_thr) ? 1'b0 : rx_f_reg);
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_m_reg <= 1'b1;
            rx_s_reg <= 1'b1;
            rx_f_reg <= 1'b1;
            dom_reg <= 16'h0;
        end else begin
            rx_m_reg <= can_rx_i;
            rx_s_reg <= rx_m_reg;
            rx_f_reg <= rx_f_next;
            dom_reg <= dom_next;
        end
    end
    // ------------------------------------------------------------
    // Clock recovery, bit timing and frame tracking
    // ------------------------------------------------------------
    logic [15:0] bt_next, prog_bt, up_bt, lo_bt, meas_reg, meas_next, cnt_reg, cnt_next;
    logic [15:0] sp_pos;
    logic [21:0] sp_prod;
    logic [3:0] idle_reg, idle_next;
    logic rx_p_reg, edge_dom, edge_any, smp, samp_reg, sbit_reg, samp_next, sbit_next;
    cdrw_state_t state_next;
    always_comb begin
        prog_bt = {8'h0, btq_reg} << clk_sel_reg;
        up_bt = {8'h0, upper_reg} << clk_sel_reg;
        lo_bt = {8'h0, lower_reg} << clk_sel_reg;
        edge_dom = rx_p_reg & ~rx_f_reg;
        // Both edge directions close a measurement, so a single bit time can be seen.
        edge_any = rx_p_reg ^ rx_f_reg;
        skip_w = (state_reg == CDRW_SKIP);
        meas_next = edge_any ? 16'h1 : ((meas_reg == 16'hFFFF) ? meas_reg : meas_reg + 16'h1);
        bt_next = bt_reg;
        if (!ctrl_reg[BIT_REC_EN]) begin
            bt_next = prog_bt;
        end else if (edge_any && !skip_w && meas_reg > bt_reg - (bt_reg >> 2)
                     && meas_reg < bt_reg + (bt_reg >> 2)) begin
            if (meas_reg > bt_reg) begin
                bt_next = bt_reg + 16'h1;
            end else if (meas_reg < bt_reg) begin
                bt_next = bt_reg - 16'h1;
            end
            if (bt_next >= up_bt || bt_next <= lo_bt) begin
                bt_next = prog_bt;
            end
        end
        // Bits shorter than the minimum bit time are not decoded.
        if (bt_next < 16'(MIN_BIT_CYC)) begin
            bt_next = 16'(MIN_BIT_CYC);
        end
        sp_prod = bt_reg * spp_reg;
        sp_pos = sp_prod[21:6];
        smp = (cnt_reg == sp_pos);
        cnt_next = (edge_dom || cnt_reg >= bt_reg - 16'h1) ? 16'h0 : cnt_reg + 16'h1;
        idle_next = idle_reg;
        if (smp && rx_f_reg && idle_reg != 4'hF) begin
            idle_next = idle_reg + 4'h1;
        end else if (smp && !rx_f_reg && !skip_w) begin
            idle_next = 4'h0;
        end else if (skip_w && !rx_f_reg && dom_reg == dom_thr) begin
            idle_next = 4'h0;
        end else if (edge_dom && !skip_w) begin
            idle_next = 4'h0;
        end
        state_next = state_reg;
        case (state_reg)
            CDRW_IDLE: begin
                if (edge_dom && idle_reg >= IDLE_BITS) begin
                    state_next = CDRW_FRAME;
                end
            end
            CDRW_FRAME: begin
                if (ctrl_reg[BIT_FD_EN] && edl_bit_i) begin
                    state_next = CDRW_SKIP;
                end else if (idle_reg >= IDLE_BITS) begin
                    state_next = CDRW_IDLE;
                end
            end
            default: begin
                if (idle_reg >= IDLE_BITS) begin
                    state_next = CDRW_IDLE;
                end
            end
        endcase
        samp_next = smp & ~skip_w;
        sbit_next = smp ? rx_f_reg : sbit_reg;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bt_reg <= {8'h0, BTQ_RST};
            meas_reg <= 16'h0;
            cnt_reg <= 16'h0;
            idle_reg <= 4'h0;
            rx_p_reg <= 1'b1;
            state_reg <= CDRW_IDLE;
            samp_reg <= 1'b0;
            sbit_reg <= 1'b1;
        end else begin
            bt_reg <= bt_next;
            meas_reg <= meas_next;
            cnt_reg <= cnt_next;
            idle_reg <= idle_next;
            rx_p_reg <= rx_f_reg;
            state_reg <= state_next;
            samp_reg <= samp_next;
            sbit_reg <= sbit_next;
        end
    end
    assign sample_strobe_o = samp_reg;
    assign sampled_bit_o = sbit_reg;
    assign frame_active_o = (state_reg == CDRW_FRAME);
    // ------------------------------------------------------------
    // Silence timeout and wake signalling
    // ------------------------------------------------------------
    logic [31:0] sil_reg, sil_next;
    logic silent_next, int_reg, int_next, vcc_reg, vcc_next, sleep_p_reg;
    always_comb begin
        sil_next = (rx_f_reg != rx_p_reg) ? 32'h0 : sil_reg;
        if (rx_f_reg == rx_p_reg && sil_reg < 32'(SILENCE_CYCLES)) begin
            sil_next = sil_reg + 32'h1;
        end
        silent_next = (sil_reg >= 32'(SILENCE_CYCLES));
        wake_evt = wake_pattern_i | wake_frame_i;
        int_next = ~(wake_next & stop_mode_i);
        vcc_next = vcc_reg;
        if (wake_evt && sleep_mode_i) begin
            vcc_next = 1'b1;
        end else if (sleep_mode_i && !sleep_p_reg) begin
            vcc_next = 1'b0;
        end else if (!sleep_mode_i) begin
            vcc_next = 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sil_reg <= 32'h0;
            silent_reg <= 1'b0;
            int_reg <= 1'b1;
            vcc_reg <= 1'b1;
            sleep_p_reg <= 1'b0;
        end else begin
            sil_reg <= sil_next;
            silent_reg <= silent_next;
            int_reg <= int_next;
            vcc_reg <= vcc_next;
            sleep_p_reg <= sleep_mode_i;
        end
    end
    assign bus_silent_o = silent_reg;
    assign interrupt_output_low_o = int_reg;
    assign main_supply_output_o = vcc_reg;
endmodule
`default_nettype wire

/* verilog/cdrw_pkg.sv */
// Constants shared by the wake clock and data recovery block.
package cdrw_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CLK = 8'h04;
    localparam logic [7:0] ADR_BTQ = 8'h08;
    localparam logic [7:0] ADR_SPP = 8'h0C;
    localparam logic [7:0] ADR_UPPER = 8'h10;
    localparam logic [7:0] ADR_LOWER = 8'h14;
    localparam logic [7:0] ADR_STATUS = 8'h18;
    localparam logic [7:0] ADR_WAKE = 8'h1C;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_REC_EN = 0;
    localparam int BIT_FD_EN = 1;
    localparam int BIT_FILT_CLASS = 2;
    localparam int BIT_RX_SEL = 3;
    localparam int BIT_ST_SILENT = 16;
    localparam int BIT_ST_FRAME = 17;
    localparam int BIT_ST_SKIP = 18;
    localparam int BIT_ST_WAKE = 19;
    localparam int BIT_WAKE_FLAG = 0;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [1:0] CLK_RST = 2'h0;
    localparam logic [7:0] BTQ_RST = 8'h14;
    localparam logic [5:0] SPP_RST = 6'h33;
    localparam logic [7:0] UPPER_RST = 8'h18;
    localparam logic [7:0] LOWER_RST = 8'h10;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int SILENCE_MS = 1000;
    localparam int SILENCE_CYC = (CLK_HZ / 1000) * SILENCE_MS;
    localparam int MIN_BIT_NS = 1000;
    localparam int MIN_BIT_CYC = (MIN_BIT_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam logic [3:0] IDLE_BITS = 4'h8;
    // Decoder states.
    typedef enum logic [1:0] {CDRW_IDLE, CDRW_FRAME, CDRW_SKIP} cdrw_state_t;
endpackage

/* tb/cdrw_can_node.sv */
// Bus node model that sends timed bit sequences on the receive pin.
`timescale 1ns/10ps
`default_nettype none
module cdrw_can_node (
    // Control
    input wire logic clk_i,
    input wire logic send_i,
    input wire logic [15:0] bt_i,
    input wire logic [7:0] bits_i,
    // Bus
    output logic rx_o,
    output logic busy_o
);
    logic [7:0] sh;
    logic [15:0] cnt;
    logic [3:0] n;
    initial begin
        rx_o = 1'h1;
        busy_o = 1'h0;
    end
    // The bus idles recessive; bits go out first bit in the top position.
    always @(posedge clk_i) begin
        if (send_i && !busy_o) begin
            sh <= bits_i;
            n <= 4'h8;
            cnt <= 16'h0;
            busy_o <= 1'h1;
            rx_o <= bits_i[7];
        end else if (busy_o) begin
            cnt <= cnt + 16'h1;
            if (cnt == bt_i - 16'h1) begin
                cnt <= 16'h0;
                sh <= {sh[6:0], 1'h1};
                n <= n - 4'h1;
                rx_o <= sh[6];
                busy_o <= (n != 4'h1);
            end
        end
    end
endmodule
`default_nettype wire

/* tb/cdrw_properties.sv */
// Port checker of the wake recovery block.
`timescale 1ns/10ps
`default_nettype none
module cdrw_properties #(
    parameter int SILENCE_CYCLES = 200
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Bus and events
    input wire logic can_rx_i,
    input wire logic wake_pattern_i,
    input wire logic wake_frame_i,
    input wire logic stop_mode_i,
    input wire logic sleep_mode_i,
    // Outputs
    input wire logic sample_strobe_o,
    input wire logic frame_active_o,
    input wire logic bus_silent_o,
    input wire logic interrupt_output_low_o,
    input wire logic main_supply_output_o
);
    logic rx_reg;
    int quiet_reg;
    logic wake;
    assign wake = wake_pattern_i || wake_frame_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Counts cycles for which the receive pin has not changed.
    always_ff @(posedge clk_i) begin
        rx_reg <= can_rx_i;
        if (rst_i || can_rx_i != rx_reg) begin
            quiet_reg <= 0;
        end else if (quiet_reg < SILENCE_CYCLES + 100) begin
            quiet_reg <= quiet_reg + 1;
        end
    end
    AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_WAKE_STOP: assert property (wake && stop_mode_i |=> !interrupt_output_low_o)
        else $error("no interrupt on wake");
    AST_INT_RUN: assert property (!stop_mode_i |=> interrupt_output_low_o)
        else $error("interrupt outside stop");
    AST_WAKE_SLEEP: assert property (wake && sleep_mode_i && $past(sleep_mode_i) |=> main_supply_output_o)
        else $error("no supply on wake");
    AST_STROBE_GAP: assert property (sample_strobe_o |=> !sample_strobe_o [*8])
        else $error("sample strobes too close");
    AST_SILENCE_DUE: assert property (quiet_reg >= SILENCE_CYCLES + 64 |-> bus_silent_o)
        else $error("silence not flagged");
    COV_FRAME: cover property ($rose(frame_active_o));
    COV_WAKE: cover property (wake && stop_mode_i);
    COV_SILENT: cover property ($rose(bus_silent_o));
endmodule
bind cdrw_recovery cdrw_properties #(.SILENCE_CYCLES(SILENCE_CYCLES)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .can_rx_i(can_rx_i),
    .wake_pattern_i(wake_pattern_i), .wake_frame_i(wake_frame_i),
    .stop_mode_i(stop_mode_i), .sleep_mode_i(sleep_mode_i),
    .sample_strobe_o(sample_strobe_o), .frame_active_o(frame_active_o),
    .bus_silent_o(bus_silent_o), .interrupt_output_low_o(interrupt_output_low_o),
    .main_supply_output_o(main_supply_output_o));
`default_nettype wire

/* tb/tb.sv */
// Self-checking testbench of the wake recovery block.
`timescale 1ns/10ps
`default_nettype none
module tb import cdrw_pkg::*; ;
    localparam int SIL = 200;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0, send = 1'h0, glitch = 1'h0;
    logic edl = 1'h0, wp = 1'h0, wf = 1'h0, stop = 1'h0, sleep = 1'h0;
    logic [7:0] adr = 8'h00, nbits = 8'h00;
    logic [15:0] nbt = 16'h0014;
    logic [31:0] wdat = 32'h0, q;
    logic [7:0] ra [7] = '{ADR_CTRL, ADR_CLK, ADR_BTQ, ADR_SPP, ADR_UPPER, ADR_LOWER, 8'h20};
    logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h14, 32'h33, 32'h18, 32'h10, 32'h0};
    wire logic [31:0] rdat;
    wire logic ack, strobe, sbit, fa, silent, interrupt_output_low, sup, node_rx, busy, can_rx;
    wire logic [2:0] outs;
    int err_count = 0, n_checks = 0, cyc_n = 0, t, s;
    assign can_rx = node_rx & ~glitch;
    assign outs = {silent, sup, fa};
    always #25 clk_i = ~clk_i;
    cdrw_recovery #(.SILENCE_CYCLES(SIL)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .can_rx_i(can_rx), .edl_bit_i(edl),
        .wake_pattern_i(wp), .wake_frame_i(wf), .stop_mode_i(stop), .sleep_mode_i(sleep),
        .sample_strobe_o(strobe), .sampled_bit_o(sbit), .frame_active_o(fa),
        .bus_silent_o(silent), .interrupt_output_low_o(interrupt_output_low), .main_supply_output_o(sup));
    cdrw_can_node node (.clk_i(clk_i), .send_i(send), .bt_i(nbt), .bits_i(nbits),
        .rx_o(node_rx), .busy_o(busy));
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'h1);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic rd_bt(input logic [31:0] e);
        wb(1'h0, ADR_STATUS, 32'h0);
        chk(q & 32'hFFFF, e);
    endtask
    // Waits a bounded time for one output to reach a level, then checks it.
    task automatic seen(input int idx, input logic v, input int n);
        for (t = 0; t < n && outs[idx] !== v; t++) @(posedge clk_i);
        chk({31'h0, outs[idx]}, {31'h0, v});
    endtask
    task automatic frame(input logic [15:0] b, input logic [7:0] p);
        @(posedge clk_i);
        nbt <= b;
        nbits <= p;
        send <= 1'h1;
        @(posedge clk_i);
        send <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic idle(input int n);
        while (busy === 1'h1) @(posedge clk_i);
        tick(n);
    endtask
    task automatic pulse_glitch();
        @(posedge clk_i);
        glitch <= 1'h1;
        tick(3);
        glitch <= 1'h0;
    endtask
    task automatic t_regs();
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], rv[i]);
        end
        wb(1'h1, 8'h20, 32'hFF);
        rd(8'h20, 32'h0);
    endtask
    task automatic t_config();
        wb(1'h1, ADR_CTRL, 32'h0);
        wb(1'h1, ADR_CLK, 32'h1);
        wb(1'h1, ADR_BTQ, 32'h14);
        rd_bt(32'h28);
        wb(1'h1, ADR_CLK, 32'h0);
        rd_bt(32'h14);
    endtask
    task automatic t_recover();
        frame(16'h0016, 8'h55);
        idle(250);
        rd_bt(32'h14);
        wb(1'h1, ADR_CTRL, 32'h1);
        frame(16'h0016, 8'h55);
        idle(250);
        wb(1'h0, ADR_STATUS, 32'h0);
        chk({31'h0, q[15:0] > 16'h0014 && q[15:0] < 16'h0018}, 32'h1);
        wb(1'h1, ADR_CTRL, 32'h0);
        wb(1'h1, ADR_UPPER, 32'h15);
        wb(1'h1, ADR_CTRL, 32'h1);
        frame(16'h0017, 8'h55);
        idle(250);
        rd_bt(32'h14);
        wb(1'h1, ADR_CTRL, 32'h0);
        wb(1'h1, ADR_UPPER, 32'h18);
    endtask
    task automatic t_frame();
        frame(16'h0014, 8'h0F);
        s = cyc_n;
        seen(0, 1'h1, 10);
        for (t = 0; t < 40 && strobe !== 1'h1; t++) @(posedge clk_i);
        chk({31'h0, sbit}, 32'h0);
        seen(0, 1'h0, 400);
        chk({31'h0, cyc_n - s >= 195 && cyc_n - s <= 300}, 32'h1);
    endtask
    task automatic t_silence();
        seen(2, 1'h1, SIL + 100);
        frame(16'h0014, 8'h00);
        seen(2, 1'h0, 10);
        idle(0);
        s = cyc_n;
        seen(2, 1'h1, SIL + 100);
        chk({31'h0, cyc_n - s >= SIL && cyc_n - s <= SIL + 40}, 32'h1);
    endtask
    task automatic t_fd();
        wb(1'h1, ADR_CLK, 32'h3);
        wb(1'h1, ADR_UPPER, 32'h18);
        wb(1'h1, ADR_LOWER, 32'h10);
        wb(1'h1, ADR_CTRL, 32'h2);
        tick(1300);
        pulse_glitch();
        tick(20);
        chk({31'h0, fa}, 32'h0);
        frame(16'h00A0, 8'h0F);
        seen(0, 1'h1, 10);
        edl <= 1'h1;
        @(posedge clk_i);
        edl <= 1'h0;
        tick(4);
        chk({31'h0, fa}, 32'h0);
        idle(1400);
        wb(1'h1, ADR_CTRL, 32'h6);
        pulse_glitch();
        seen(0, 1'h1, 20);
        seen(0, 1'h0, 1600);
        wb(1'h1, ADR_CTRL, 32'hA);
        pulse_glitch();
        seen(0, 1'h1, 20);
        seen(0, 1'h0, 1600);
        wb(1'h1, ADR_CTRL, 32'h0);
    endtask
    task automatic t_wake();
        @(posedge clk_i);
        stop <= 1'h1;
        wf <= 1'h1;
        @(posedge clk_i);
        wf <= 1'h0;
        @(posedge clk_i);
        chk({31'h0, interrupt_output_low}, 32'h0);
        wb(1'h1, ADR_WAKE, 32'h1);
        tick(2);
        chk({31'h0, interrupt_output_low}, 32'h1);
        stop <= 1'h0;
        sleep <= 1'h1;
        seen(1, 1'h0, 5);
        wp <= 1'h1;
        @(posedge clk_i);
        wp <= 1'h0;
        seen(1, 1'h1, 2);
        sleep <= 1'h0;
    endtask
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 40000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        tick(10);
        rst_i <= 1'h0;
        t_regs();
        t_config();
        t_recover();
        t_frame();
        t_silence();
        t_fd();
        t_wake();
        close_out();
    end
endmodule
`default_nettype wire
